/* hw/ltm_pkg.sv */
package ltm_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_WRAP = 8'h08;
  localparam logic [7:0] ADDR_THR = 8'h0c;
  localparam logic [7:0] ADDR_TALLY = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int FLAG_LIMIT_BIT = 0;
  localparam int FLAG_MATCH_BIT = 1;
  localparam int CFG_WIDTH = 12;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam logic [15:0] WRAP_RESET = 16'h0000;
  localparam logic [15:0] THR_RESET = 16'h0000;

  // ----------------------------------------
  // encodings
  // ----------------------------------------
  localparam logic [1:0] TRIG_SW = 2'b00;
  localparam logic [1:0] SEL_RISE = 2'b01;
  localparam logic [1:0] SEL_FALL = 2'b10;
  localparam logic [1:0] SEL_BOTH = 2'b11;

  // ----------------------------------------
  // latency counts in cycles, kernel ticks or input edges
  // ----------------------------------------
  localparam logic [1:0] BUS_LAT = 2'd2;
  localparam logic [1:0] KER_LAT = 2'd2;
  localparam logic [1:0] ENABLE_TICKS = 2'd2;
  localparam logic [2:0] LOST_EDGES = 3'd5;

  // ----------------------------------------
  // types
  // ----------------------------------------
  // lsb first: src_ext at bit 0 up to reload at bit 11
  typedef struct packed {
    logic reload;
    logic out_pol;
    logic one_time;
    logic [1:0] trig_cfg;
    logic [1:0] edge_pol;
    logic [2:0] div_sel;
    logic ext_count;
    logic src_ext;
  } ltm_cfg_type;

  typedef enum logic [2:0] {
    ST_OFF, ST_WARM, ST_READY, ST_ARMED, ST_RUN, ST_HOLD
  } ltm_state_type;

  // sel: 01 rising, 10 falling, 11 both, 00 none
  function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                    input logic prev);
    return (sel[0] & now & ~prev) | (sel[1] & ~now & prev);
  endfunction : edge_hit

endpackage : ltm_pkg

/* hw/ltm_tick_gen.sv */
`timescale 1ns/1ps
module ltm_tick_gen
  import ltm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input ltm_cfg_type i_cfg,
  input wire logic i_timer_on,
  input wire logic i_primary_input,
  output logic o_tick
);

  logic in_d_ff;
  logic nxt_in_d;
  logic [6:0] presc_ff;
  logic [6:0] nxt_presc;
  logic [2:0] lost_ff;
  logic [2:0] nxt_lost;
  logic tick_ff;
  logic nxt_tick;
  logic [1:0] sel;
  logic [6:0] mask;
  logic hit;

  // ----------------------------------------
  // kernel tick source
  // ----------------------------------------
  always_comb begin
    if (i_cfg.src_ext) begin
      sel = i_cfg.edge_pol[0] ? SEL_FALL : SEL_RISE;
    end else if (i_cfg.edge_pol[1]) begin
      sel = SEL_BOTH;
    end else begin
      sel = i_cfg.edge_pol[0] ? SEL_FALL : SEL_RISE;
    end
    mask = 7'((8'h01 << i_cfg.div_sel) - 8'h01);
    hit = edge_hit(sel, i_primary_input, in_d_ff);
    nxt_in_d = i_primary_input;
    nxt_presc = presc_ff;
    nxt_lost = lost_ff;
    nxt_tick = 1'b0;
    if (!i_timer_on) begin
      nxt_presc = 7'h00;
      nxt_lost = 3'h0;
    end else if (i_cfg.src_ext) begin
      // the kernel runs off the input itself, so its first edges are swallowed
      if (hit) begin
        if (lost_ff < LOST_EDGES) begin
          nxt_lost = lost_ff + 3'h1;
        end else begin
          nxt_tick = 1'b1;
        end
      end
    end else if (!i_cfg.ext_count || hit) begin
      if (presc_ff >= mask) begin
        nxt_presc = 7'h00;
        nxt_tick = 1'b1;
      end else begin
        nxt_presc = presc_ff + 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      in_d_ff <= 1'b0;
      presc_ff <= 7'h00;
      lost_ff <= 3'h0;
      tick_ff <= 1'b0;
    end else begin
      in_d_ff <= nxt_in_d;
      presc_ff <= nxt_presc;
      lost_ff <= nxt_lost;
      tick_ff <= nxt_tick;
    end
  end

  assign o_tick = tick_ff;

endmodule : ltm_tick_gen

/* hw/ltm_core.sv */
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Function
// - continuous mode runs from its trigger until software turns the timer off
// - one-shot mode starts on a trigger and stops at the wrap limit
// - continuous start begins at once by software, else next trigger; later triggers ignored
// - start bit writes count only while the timer-on bit is one
// - start bits switch mode on the fly; change acts at wrap limit
// - one-shot ignores triggers while counting; later trigger starts a new run
// - with external trigger, each edge after a one-shot stop starts a run
// - output-shape bit: start once on first trigger, ignore all later triggers
// - with software trigger, single start itself starts one one-shot run
// - pwm output sets at threshold match and clears at wrap match
// - one-pulse output is pwm for one run, then stays cleared
// - one-time output keeps its final level instead of clearing
// - shape bit clear gives pwm or one-pulse by start bit, set gives one-time
// - polarity bit inverts output at once, even while disabled
// - internal clock counting reaches output rate of kernel clock over two
// - deferred update while running loads new values at overflow after bus delay
// - immediate update loads after two bus cycles plus two kernel ticks
// - write-done flags set when the new value reaches the counting logic
// - internal source counts clock pulses or sampled primary input edges
// - external source counts one edge kind; first five edges after enable lost
// - timer works only two kernel ticks after the timer-on bit is set
// - external trigger edges pass a two tick synchroniser before use
module ltm_core
  import ltm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_primary_input,
  input wire logic i_trigger,
  output logic o_wave,
  output logic o_counting
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic on_ff;
  logic nxt_on;
  ltm_cfg_type cfg_ff;
  ltm_cfg_type nxt_cfg;
  logic [1:0] flags_ff;
  logic [1:0] nxt_flags;
  logic req_cont_ff;
  logic nxt_req_cont;
  logic req_single_ff;
  logic nxt_req_single;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;

  logic [1:0][15:0] pre_ff;
  logic [1:0][15:0] nxt_pre;
  logic [1:0][15:0] act_ff;
  logic [1:0][15:0] nxt_act;
  logic [1:0][1:0] bcnt_ff;
  logic [1:0][1:0] nxt_bcnt;
  logic [1:0][1:0] kcnt_ff;
  logic [1:0][1:0] nxt_kcnt;
  logic [1:0] pend_ff;
  logic [1:0] nxt_pend;
  logic [1:0] load;
  logic [1:0] wr_reg;

  ltm_state_type state_ff;
  ltm_state_type nxt_state;
  logic mode_ff;
  logic nxt_mode;
  logic go_ff;
  logic nxt_go;
  logic [1:0] warm_ff;
  logic [1:0] nxt_warm;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic raw_ff;
  logic nxt_raw;
  logic [2:0] trig_ff;
  logic [2:0] nxt_trig;
  logic wave_ff;
  logic nxt_wave;
  logic counting_ff;
  logic nxt_counting;

  logic tick;
  logic apb_wr;
  logic apb_setup;
  logic trig_ev;
  logic ovf;
  logic sw_trig;

  assign apb_wr = i_psel & i_penable & pready_ff & i_pwrite;
  assign apb_setup = i_psel & ~i_penable;

  // ----------------------------------------
  // kernel tick
  // ----------------------------------------
  ltm_tick_gen u_tick (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_cfg(cfg_ff),
    .i_timer_on(on_ff),
    .i_primary_input(i_primary_input),
    .o_tick(tick)
  );

  // ----------------------------------------
  // apb slave and software registers
  // ----------------------------------------
  // zero wait states: pready rises for the access phase right after setup
  always_comb begin
    nxt_on = on_ff;
    nxt_cfg = cfg_ff;
    nxt_flags = flags_ff;
    nxt_req_cont = 1'b0;
    nxt_req_single = 1'b0;
    nxt_prdata = prdata_ff;
    nxt_pready = apb_setup;
    nxt_pslverr = 1'b0;
    if (apb_setup && !i_pwrite) begin
      if (i_paddr == ADDR_CTRL) begin
        nxt_prdata = {31'h0, on_ff};
      end else if (i_paddr == ADDR_CFG) begin
        nxt_prdata = {20'h0, cfg_ff};
      end else if (i_paddr == ADDR_WRAP) begin
        nxt_prdata = {16'h0, pre_ff[0]};
      end else if (i_paddr == ADDR_THR) begin
        nxt_prdata = {16'h0, pre_ff[1]};
      end else if (i_paddr == ADDR_TALLY) begin
        nxt_prdata = {16'h0, cnt_ff};
      end else if (i_paddr == ADDR_FLAGS) begin
        nxt_prdata = {30'h0, flags_ff};
      end else begin
        nxt_prdata = 32'h0;
        nxt_pslverr = 1'b1;
      end
    end else if (apb_setup) begin
      if (i_paddr != ADDR_CTRL && i_paddr != ADDR_CFG && i_paddr != ADDR_WRAP &&
          i_paddr != ADDR_THR && i_paddr != ADDR_FLAGS) begin
        nxt_pslverr = 1'b1;
      end
    end
    if (apb_wr) begin
      if (i_paddr == ADDR_CTRL) begin
        nxt_on = i_pwdata[CTRL_ON_BIT];
        // start bits are dropped unless the timer was already on
        nxt_req_cont = on_ff & i_pwdata[CTRL_CONT_BIT];
        nxt_req_single = on_ff & i_pwdata[CTRL_SINGLE_BIT];
      end else if (i_paddr == ADDR_CFG) begin
        nxt_cfg = i_pwdata[CFG_WIDTH-1:0];
      end else if (i_paddr == ADDR_FLAGS) begin
        nxt_flags = flags_ff & ~i_pwdata[1:0];
      end
    end
    // a completion in the clearing cycle is kept
    nxt_flags = nxt_flags | load;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      on_ff <= 1'b0;
      cfg_ff <= CFG_RESET;
      flags_ff <= 2'b00;
      req_cont_ff <= 1'b0;
      req_single_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      on_ff <= nxt_on;
      cfg_ff <= nxt_cfg;
      flags_ff <= nxt_flags;
      req_cont_ff <= nxt_req_cont;
      req_single_ff <= nxt_req_single;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ----------------------------------------
  // wrap limit and threshold update path
  // ----------------------------------------
  // index 0 is the wrap limit, index 1 the threshold
  always_comb begin
    wr_reg[0] = apb_wr & (i_paddr == ADDR_WRAP);
    wr_reg[1] = apb_wr & (i_paddr == ADDR_THR);
    for (int i = 0; i < 2; i++) begin
      nxt_pre[i] = pre_ff[i];
      nxt_act[i] = act_ff[i];
      nxt_bcnt[i] = bcnt_ff[i];
      nxt_kcnt[i] = kcnt_ff[i];
      nxt_pend[i] = pend_ff[i];
      load[i] = 1'b0;
      if (wr_reg[i]) begin
        // a rewrite while pending restarts the path; its result is not defined
        nxt_pre[i] = i_pwdata[15:0];
        nxt_bcnt[i] = BUS_LAT;
        nxt_kcnt[i] = KER_LAT;
        nxt_pend[i] = 1'b1;
      end else if (pend_ff[i]) begin
        if (bcnt_ff[i] != 2'd0) begin
          nxt_bcnt[i] = bcnt_ff[i] - 2'd1;
        end else if (cfg_ff.reload && state_ff == ST_RUN) begin
          load[i] = ovf;
        end else if (tick) begin
          if (kcnt_ff[i] > 2'd1) begin
            nxt_kcnt[i] = kcnt_ff[i] - 2'd1;
          end else begin
            load[i] = 1'b1;
          end
        end
      end
      if (load[i]) begin
        nxt_act[i] = pre_ff[i];
        nxt_pend[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pre_ff[0] <= WRAP_RESET;
      pre_ff[1] <= THR_RESET;
      act_ff[0] <= WRAP_RESET;
      act_ff[1] <= THR_RESET;
      bcnt_ff <= '0;
      kcnt_ff <= '0;
      pend_ff <= 2'b00;
    end else begin
      pre_ff <= nxt_pre;
      act_ff <= nxt_act;
      bcnt_ff <= nxt_bcnt;
      kcnt_ff <= nxt_kcnt;
      pend_ff <= nxt_pend;
    end
  end

  // ----------------------------------------
  // counting state machine and waveform
  // ----------------------------------------
  always_comb begin
    sw_trig = (cfg_ff.trig_cfg == TRIG_SW);
    nxt_trig = trig_ff;
    if (tick) begin
      nxt_trig = {trig_ff[1:0], i_trigger};
    end
    trig_ev = tick & ~sw_trig & edge_hit(cfg_ff.trig_cfg, trig_ff[1], trig_ff[2]);
    ovf = tick & (state_ff == ST_RUN) & (cnt_ff == act_ff[0]);
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_go = go_ff;
    nxt_warm = warm_ff;
    nxt_cnt = cnt_ff;
    nxt_raw = raw_ff;
    if (req_cont_ff) begin
      nxt_mode = 1'b1;
      nxt_go = 1'b1;
    end else if (req_single_ff) begin
      nxt_mode = 1'b0;
      nxt_go = 1'b1;
    end
    if (!on_ff) begin
      nxt_state = ST_OFF;
      nxt_go = 1'b0;
      nxt_warm = 2'd0;
      nxt_cnt = 16'h0;
      nxt_raw = 1'b0;
    end else begin
      case (state_ff)
        ST_OFF: begin
          nxt_state = ST_WARM;
          nxt_warm = 2'd0;
        end
        ST_WARM: begin
          if (tick) begin
            if (warm_ff == ENABLE_TICKS - 2'd1) begin
              nxt_state = ST_READY;
            end else begin
              nxt_warm = warm_ff + 2'd1;
            end
          end
        end
        ST_READY: begin
          if (go_ff) begin
            nxt_go = 1'b0;
            nxt_cnt = 16'h0;
            if (sw_trig) begin
              nxt_state = ST_RUN;
            end else begin
              nxt_state = ST_ARMED;
            end
          end
        end
        ST_ARMED: begin
          nxt_go = 1'b0;
          if (trig_ev) begin
            nxt_state = ST_RUN;
            nxt_cnt = 16'h0;
          end
        end
        ST_RUN: begin
          // triggers are not looked at while counting
          nxt_go = 1'b0;
          if (tick) begin
            if (cnt_ff == act_ff[1]) begin
              nxt_raw = 1'b1;
            end
            if (cnt_ff == act_ff[0]) begin
              nxt_cnt = 16'h0;
              if (!cfg_ff.one_time) begin
                nxt_raw = 1'b0;
              end
              if (!mode_ff) begin
                if (cfg_ff.one_time) begin
                  nxt_state = ST_HOLD;
                end else if (sw_trig) begin
                  nxt_state = ST_READY;
                end else begin
                  nxt_state = ST_ARMED;
                end
              end
            end else begin
              nxt_cnt = cnt_ff + 16'h1;
            end
          end
        end
        ST_HOLD: begin
          // one-time run is over: output level frozen, nothing restarts it
          nxt_go = 1'b0;
        end
        default: begin
          nxt_state = ST_OFF;
        end
      endcase
    end
    nxt_wave = raw_ff ^ cfg_ff.out_pol;
    nxt_counting = (state_ff == ST_RUN);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_ff <= ST_OFF;
      mode_ff <= 1'b0;
      go_ff <= 1'b0;
      warm_ff <= 2'd0;
      cnt_ff <= 16'h0;
      raw_ff <= 1'b0;
      trig_ff <= 3'h0;
      wave_ff <= 1'b0;
      counting_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      go_ff <= nxt_go;
      warm_ff <= nxt_warm;
      cnt_ff <= nxt_cnt;
      raw_ff <= nxt_raw;
      trig_ff <= nxt_trig;
      wave_ff <= nxt_wave;
      counting_ff <= nxt_counting;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_wave = wave_ff;
  assign o_counting = counting_ff;

endmodule : ltm_core

/* sim/ltm_far_side.sv */
`timescale 1ns/1ps
module ltm_far_side
  import ltm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_fire,
  input wire logic i_toggle_en,
  output logic o_trigger,
  output logic o_primary_input
);
  logic [2:0] hold_ff, nxt_hold;
  logic half_ff, nxt_half;
  logic pin_ff, nxt_pin;
  // ----------------------------------------
  // trigger and pulse source
  // ----------------------------------------
  // trigger held four cycles so a slow synchroniser still sees the edge
  always_comb begin
    nxt_hold = i_fire ? 3'h4 : ((hold_ff != 3'h0) ? hold_ff - 3'h1 : 3'h0);
    nxt_half = i_toggle_en ? ~half_ff : 1'b0;
    nxt_pin = (i_toggle_en && half_ff) ? ~pin_ff : pin_ff;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      hold_ff <= 3'h0;
      half_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      half_ff <= nxt_half;
      pin_ff <= nxt_pin;
    end
  end
  assign o_trigger = (hold_ff != 3'h0);
  assign o_primary_input = pin_ff;
endmodule : ltm_far_side

/* sim/ltm_core_props.sv */
`timescale 1ns/1ps
module ltm_core_props
  import ltm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_primary_input,
  input wire logic i_trigger,
  input wire logic o_wave,
  input wire logic o_counting
);
  logic on_ff, nxt_on, cont_ff, nxt_cont, wr_done, mapped;
  ltm_cfg_type cfg_ff, nxt_cfg;
  // ----------------------------------------
  // shadow of what software wrote
  // ----------------------------------------
  assign wr_done = i_psel & i_penable & i_pwrite & o_pready;
  assign mapped = i_paddr inside {ADDR_CTRL, ADDR_CFG, ADDR_WRAP, ADDR_THR, ADDR_TALLY, ADDR_FLAGS};
  always_comb begin
    nxt_on = on_ff;
    nxt_cont = cont_ff;
    nxt_cfg = cfg_ff;
    if (wr_done && i_paddr == ADDR_CTRL) begin
      nxt_on = i_pwdata[CTRL_ON_BIT];
      if (on_ff && i_pwdata[CTRL_CONT_BIT]) begin
        nxt_cont = 1'b1;
      end else if (on_ff && i_pwdata[CTRL_SINGLE_BIT]) begin
        nxt_cont = 1'b0;
      end
    end
    if (wr_done && i_paddr == ADDR_CFG) begin
      nxt_cfg = i_pwdata[11:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      on_ff <= 1'b0;
      cont_ff <= 1'b0;
      cfg_ff <= CFG_RESET;
    end else begin
      on_ff <= nxt_on;
      cont_ff <= nxt_cont;
      cfg_ff <= nxt_cfg;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (i_psel && !i_penable && !mapped |=> o_pslverr)
    else $error("no error on unmapped address");
  a_err_read_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h00000000)
    else $error("error read returned data");
  a_off_quiet: assert property ((!on_ff)[*4] |-> !o_counting)
    else $error("counting while timer off");
  a_warm_quiet: assert property ($rose(on_ff) |-> (!o_counting)[*3])
    else $error("counting during warm up");
  a_drop_start: assert property (wr_done && i_paddr == ADDR_CTRL && !on_ff
    && (|i_pwdata[2:1]) |=> (!o_counting)[*8])
    else $error("start bit taken while off");
  a_cont_holds: assert property (o_counting && on_ff && cont_ff && $past(cont_ff, 3)
    && !cfg_ff.one_time |=> o_counting)
    else $error("continuous run stopped");
  a_one_time_hold: assert property (cfg_ff.one_time && on_ff && $fell(o_counting)
    |-> (!o_counting)[*8])
    else $error("one-time run restarted");
  a_idle_level: assert property (!o_counting && !$past(o_counting) && !cfg_ff.one_time
    |-> o_wave == $past(cfg_ff.out_pol))
    else $error("idle output not at polarity");
endmodule : ltm_core_props

bind ltm_core ltm_core_props ltm_core_props_i (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_primary_input, .i_trigger, .o_wave,
  .o_counting);

/* sim/ltm_core_tb.sv */
`timescale 1ns/1ps
module ltm_core_tb;
  import ltm_pkg::*;
  logic i_clk = 1'b0, i_rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic fire = 1'b0, toggle_en = 1'b0, pready, pslverr, prim, trig, wave, counting;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h1f;
  logic [32:0] expq[$];
  logic [7:0] regs[6] = '{ADDR_CTRL, ADDR_CFG, ADDR_WRAP, ADDR_THR, ADDR_TALLY, ADDR_FLAGS};
  logic [15:0] wv, tv;
  int errors = 0, checked = 0, wave_hi, rises;
  ltm_core ltm_core_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_primary_input(prim), .i_trigger(trig), .o_wave(wave),
    .o_counting(counting));
  ltm_far_side ltm_far_side_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_fire(fire),
    .i_toggle_en(toggle_en), .o_trigger(trig), .o_primary_input(prim));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift
  task check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task test_done();
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask : idle
  // request held until pready is sampled high, released only after that edge
  task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // no wait-state count is assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task setlim(input logic [15:0] w, input logic [15:0] t);
    wr(ADDR_WRAP, {16'h0, w});
    wr(ADDR_THR, {16'h0, t});
    idle(20);
  endtask : setlim
  // trigger pulses at cycles f1 and f2 of the window; -1 means none
  task watch(input int n, input int f1, input int f2);
    logic was;
    wave_hi = 0;
    rises = 0;
    was = counting;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      fire <= (i == f1 || i == f2);
      if (wave === 1'b1) wave_hi++;
      if (counting === 1'b1 && was !== 1'b1) rises++;
      was = counting;
    end
  endtask : watch
  // read results are compared against the oldest note
  always @(posedge i_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      check({pslverr, prdata}, (expq.size() > 0) ? expq.pop_front() : 33'hx);
    end
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    test_done();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    foreach (regs[k]) rd(regs[k], 33'h0);
    rd(8'h18, 33'h100000000);
    wr(8'h1c, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    idle(10);
    seed = xorshift(seed);
    wv = seed[15:0] | 16'h0100;
    tv = {8'h00, seed[23:16]};
    setlim(wv, tv);
    rd(ADDR_FLAGS, 33'h3);
    rd(ADDR_WRAP, {17'h0, wv});
    rd(ADDR_THR, {17'h0, tv});
    wr(ADDR_FLAGS, 32'h3);
    rd(ADDR_FLAGS, 33'h0);
    setlim(16'h3, 16'h1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h80);
    wr(ADDR_CTRL, 32'h1);
    idle(10);
    wr(ADDR_CTRL, 32'h5);
    idle(10);
    check({32'h0, counting}, 33'h0);
    watch(30, 0, -1);
    check(33'(rises), 33'd1);
    watch(40, 5, -1);
    check(33'(wave_hi), 33'd20);
    check(33'(rises), 33'd0);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h400);
    idle(3);
    check({32'h0, wave}, 33'h1);
    wr(ADDR_CFG, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    idle(12);
    check({32'h0, counting}, 33'h0);
    setlim(16'h9, 16'h1);
    wr(ADDR_CTRL, 32'h3);
    watch(40, -1, -1);
    check(33'(rises), 33'd1);
    check(33'(wave_hi), 33'd8);
    wr(ADDR_CTRL, 32'h3);
    watch(40, -1, -1);
    check(33'(rises), 33'd1);
    wr(ADDR_CTRL, 32'h5);
    watch(30, -1, -1);
    check(33'(rises), 33'd1);
    wr(ADDR_CTRL, 32'h3);
    watch(40, -1, -1);
    check({32'h0, counting}, 33'h0);
    wr(ADDR_CTRL, 32'h3);
    // switch to continuous just before the first wrap of this one-shot run
    idle(6);
    wr(ADDR_CTRL, 32'h5);
    watch(40, -1, -1);
    check({32'h0, counting}, 33'h1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h80);
    wr(ADDR_CTRL, 32'h1);
    idle(10);
    wr(ADDR_CTRL, 32'h3);
    watch(40, 0, 6);
    check(33'(rises), 33'd1);
    watch(40, 0, -1);
    check(33'(rises), 33'd1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h200);
    wr(ADDR_CTRL, 32'h1);
    idle(10);
    wr(ADDR_CTRL, 32'h3);
    watch(40, -1, -1);
    check(33'(rises), 33'd1);
    wr(ADDR_CTRL, 32'h3);
    watch(40, -1, -1);
    check(33'(rises), 33'd0);
    check(33'(wave_hi), 33'd40);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h800);
    wr(ADDR_CTRL, 32'h1);
    idle(10);
    setlim(16'hff, 16'h1);
    wr(ADDR_FLAGS, 32'h3);
    wr(ADDR_CTRL, 32'h5);
    // long wrap running: the new limit must wait for the overflow
    wr(ADDR_WRAP, 32'h9);
    idle(10);
    rd(ADDR_FLAGS, 33'h0);
    idle(300);
    rd(ADDR_FLAGS, 33'h1);
    watch(40, -1, -1);
    check(33'(wave_hi), 33'd32);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h1);
    toggle_en <= 1'b1;
    wr(ADDR_CTRL, 32'h1);
    idle(10);
    wr(ADDR_CTRL, 32'h5);
    watch(300, -1, -1);
    check(33'(rises), 33'd1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CFG, 32'h102);
    wr(ADDR_CTRL, 32'h1);
    idle(20);
    wr(ADDR_CTRL, 32'h3);
    watch(20, -1, -1);
    check(33'(rises), 33'd0);
    watch(80, 0, -1);
    check(33'(rises), 33'd1);
    check(33'(wave_hi), 33'd32);
    test_done();
  end
endmodule : ltm_core_tb
